// ---- hw/tmc_pkg.sv ----
package tmc_pkg;
    // --------------------------------------------------------------
    // Byte-wide register map of the timer
    // --------------------------------------------------------------
    localparam logic [3:0] TMC_A_CNT_L  = 4'h0;
    localparam logic [3:0] TMC_A_CNT_H  = 4'h1;
    localparam logic [3:0] TMC_A_CMPA_L = 4'h2;
    localparam logic [3:0] TMC_A_CMPA_H = 4'h3;
    localparam logic [3:0] TMC_A_CMPB_L = 4'h4;
    localparam logic [3:0] TMC_A_CMPB_H = 4'h5;
    localparam logic [3:0] TMC_A_CMPC_L = 4'h6;
    localparam logic [3:0] TMC_A_CMPC_H = 4'h7;
    localparam logic [3:0] TMC_A_CAP_L  = 4'h8;
    localparam logic [3:0] TMC_A_CAP_H  = 4'h9;
    localparam logic [3:0] TMC_A_CTLA   = 4'ha;
    localparam logic [3:0] TMC_A_CTLB   = 4'hb;
    localparam logic [3:0] TMC_A_CTLC   = 4'hc;
    localparam logic [3:0] TMC_A_FLAG   = 4'hd;
    localparam logic [3:0] TMC_A_MASK   = 4'he;
    // --------------------------------------------------------------
    // Fields
    // --------------------------------------------------------------
    localparam int TMC_CS_LSB   = 0;   // control B [2:0] clock select
    localparam int TMC_WGM_LSB  = 3;   // control B [6:3] waveform mode
    localparam int TMC_ICES_BIT = 7;   // control B: capture edge, 1 = rising
    localparam int TMC_ICNC_BIT = 7;   // control A: noise filter on
    localparam int TMC_FL_OVF   = 0;
    localparam int TMC_FL_CMPA  = 1;
    localparam int TMC_FL_CMPB  = 2;
    localparam int TMC_FL_CMPC  = 3;
    localparam int TMC_FL_CAP   = 4;
    localparam int TMC_FL_W     = 5;
    localparam logic [15:0] TMC_FLOOR  = 16'h0000;
    localparam logic [15:0] TMC_MAX    = 16'hffff;
    localparam logic [15:0] TMC_TOP8   = 16'h00ff;
    localparam logic [15:0] TMC_TOP9   = 16'h01ff;
    localparam logic [15:0] TMC_TOP10  = 16'h03ff;
    localparam int          TMC_FILT_N = 4;
    localparam logic [3:0]  TMC_WGM_PWM_OCA = 4'hf;
    localparam logic [3:0]  TMC_WGM_CTC_OCA = 4'h4;
    localparam logic [3:0]  TMC_WGM_PWM_CAP = 4'he;
    localparam logic [3:0]  TMC_WGM_CTC_CAP = 4'hc;
    localparam logic [7:0]  TMC_BYTE0  = 8'h00;
    // --------------------------------------------------------------
    // Clock select codes and host states
    // --------------------------------------------------------------
    localparam logic [2:0] TMC_CS_OFF  = 3'h0;
    localparam logic [2:0] TMC_CS_SYS  = 3'h1;
    localparam logic [2:0] TMC_CS_D8   = 3'h2;
    localparam logic [2:0] TMC_CS_D64  = 3'h3;
    localparam logic [2:0] TMC_CS_D256 = 3'h4;
    localparam logic [2:0] TMC_CS_D1K  = 3'h5;
    localparam logic [2:0] TMC_CS_EXTF = 3'h6;
    localparam logic [9:0] TMC_PRE_D8   = 10'h007;
    localparam logic [9:0] TMC_PRE_D64  = 10'h03f;
    localparam logic [9:0] TMC_PRE_D256 = 10'h0ff;
    localparam logic [9:0] TMC_PRE_D1K  = 10'h3ff;
    localparam logic [31:0] TMC_APB_CMD  = 32'h0000_0000;
    localparam logic [31:0] TMC_APB_STAT = 32'h0000_0004;
    localparam logic [31:0] TMC_APB_RDAT = 32'h0000_0008;
    localparam int TMC_CMD_GO   = 31;
    localparam int TMC_CMD_WR   = 30;
    localparam int TMC_CMD_WIDE = 29;
    typedef enum logic [2:0] {
        TMC_H_IDLE, TMC_H_FIRST, TMC_H_GAP, TMC_H_SECOND, TMC_H_DONE
    } tmc_hstate_t;
endpackage

// ---- hw/tmc_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface tmc_if (
    input wire logic pclk,
    input wire logic presetn
);
    logic [3:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       wr;
    logic       rd;
    logic       irq;
    modport dev  (input addr, wdata, wr, rd, output rdata, irq);
    modport host (output addr, wdata, wr, rd, input rdata, irq);
endinterface
`default_nettype wire

// ---- hw/tmc_dev.sv ----
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// R01: One shared 8-bit upper-byte holding register
// R02: Wide registers moved as two byte accesses
// R03: Low-byte write loads held high together
// R04: Low-byte read copies high into holding
// R05: Compare reads bypass the holding register
// R06: Host writes high byte before low
// R07: Host reads low byte before high
// R08: Host masks interrupts around paired access; the host here masks nothing and issues the pair in hardware
// R09: Control registers single byte, no holding
// R10: Each request flagged and masked individually
// R11: Counter advances only on selected tick
// R12: Compares checked against counter every cycle
// R13: Compare match sets its channel flag
// R14: Qualifying capture edge copies counter
// R15: Optional filter suppresses capture spikes
// R16: Floor 0x0000, absolute maximum 0xFFFF
// R17: Ceiling fixed, compare A or capture
// R18: Compare A as ceiling: no PWM, buffered
// R19: Legacy mode keeps only channels A, B
// R20: Processor counter write beats count/clear
// R21: Capture flag set with capture copy
// R22: High-byte write touches holding only
// R23: Counter/capture high read returns holding
module tmc_dev (
    input  wire logic pclk,
    input  wire logic presetn,
    tmc_if.dev        bus,
    input  wire logic legacy_mode,
    input  wire logic external_count_pin,
    input  wire logic capture_input_pin,
    input  wire logic comparator_in,
    input  wire logic capture_sel_cmp,
    output logic [2:0] compare_output_pins,
    output logic [15:0] counter_value
);
    import tmc_pkg::*;
    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    logic [7:0]  hold_r;  // R01
    logic [15:0] cnt_r;
    logic [15:0] cmp_r [3];
    logic [15:0] cmp_buf_r [3];
    logic [15:0] cap_r;
    logic [7:0]  ctla_r, ctlb_r, ctlc_r;
    logic [TMC_FL_W-1:0] flag_r, mask_r;
    logic [9:0]  pre_r;
    logic        ext_s_r, ext_d_r, cap_s_r;
    logic [TMC_FILT_N-1:0] filt_r;
    logic [7:0]  rdata_r;
    logic        irq_r;
    logic [2:0]  oc_r;
    // --------------------------------------------------------------
    // Decode
    // --------------------------------------------------------------
    wire [2:0] cs  = ctlb_r[TMC_CS_LSB +: 3];
    wire [3:0] wgm = ctlb_r[TMC_WGM_LSB +: 4];
    wire wr_cnt_l  = bus.wr && bus.addr == TMC_A_CNT_L;
    wire wr_cap_l  = bus.wr && bus.addr == TMC_A_CAP_L;
    wire wr_hi     = bus.wr && (bus.addr == TMC_A_CNT_H || bus.addr == TMC_A_CMPA_H ||
                     bus.addr == TMC_A_CMPB_H || bus.addr == TMC_A_CMPC_H ||
                     bus.addr == TMC_A_CAP_H);
    wire rd_cnt_l  = bus.rd && bus.addr == TMC_A_CNT_L;
    wire rd_cap_l  = bus.rd && bus.addr == TMC_A_CAP_L;
    wire [15:0] wide_w = {hold_r, bus.wdata};
    // Compare channel C absent in legacy mode
    wire [2:0] ch_en = {~legacy_mode, 2'b11};  // R19
    wire [2:0] cmp_wr;
    wire [2:0] match;
    // Ceiling by waveform mode
    wire top_oca = wgm == TMC_WGM_PWM_OCA || wgm == TMC_WGM_CTC_OCA;
    wire top_cap = wgm == TMC_WGM_PWM_CAP || wgm == TMC_WGM_CTC_CAP;
    wire [15:0] top = top_oca ? cmp_r[0] :                   // R17
                      top_cap ? cap_r :
                      wgm[1:0] == 2'h1 ? TMC_TOP8 :
                      wgm[1:0] == 2'h2 ? TMC_TOP9 :
                      wgm[1:0] == 2'h3 ? TMC_TOP10 : TMC_MAX;   // R16
    // Tick source selection
    wire ext_rise = ext_s_r & ~ext_d_r;
    wire ext_fall = ~ext_s_r & ext_d_r;
    logic tick;
    always_comb begin
        unique case (cs)  // R11
            TMC_CS_OFF:  tick = 1'b0;
            TMC_CS_SYS:  tick = 1'b1;
            TMC_CS_D8:   tick = (pre_r & TMC_PRE_D8) == TMC_PRE_D8;
            TMC_CS_D64:  tick = (pre_r & TMC_PRE_D64) == TMC_PRE_D64;
            TMC_CS_D256: tick = (pre_r & TMC_PRE_D256) == TMC_PRE_D256;
            TMC_CS_D1K:  tick = pre_r == TMC_PRE_D1K;
            TMC_CS_EXTF: tick = ext_fall;
            default:     tick = ext_rise;
        endcase
    end
    wire at_top  = cnt_r == top;
    wire [15:0] cnt_nxt = at_top ? TMC_FLOOR : cnt_r + 16'h0001;
    // Capture trigger with optional filter
    wire filt_on  = ctla_r[TMC_ICNC_BIT];
    wire filt_hi  = &filt_r;
    wire filt_lo  = ~|filt_r;
    logic cap_lvl_r;
    wire cap_lvl  = filt_on ? (filt_hi ? 1'b1 : filt_lo ? 1'b0 : cap_lvl_r) : cap_s_r;  // R15
    wire cap_evt  = ctlb_r[TMC_ICES_BIT] ? (cap_lvl & ~cap_lvl_r) : (~cap_lvl & cap_lvl_r);
    wire [TMC_FL_W-1:0] fl_set;
    // Read mux: compares direct, counter/capture high from holding
    logic [7:0] rd_mux;
    always_comb begin
        unique case (bus.addr)
            TMC_A_CNT_L:  rd_mux = cnt_r[7:0];
            TMC_A_CMPA_L: rd_mux = cmp_r[0][7:0];
            TMC_A_CMPA_H: rd_mux = cmp_r[0][15:8];  // R05
            TMC_A_CMPB_L: rd_mux = cmp_r[1][7:0];
            TMC_A_CMPB_H: rd_mux = cmp_r[1][15:8];
            TMC_A_CMPC_L: rd_mux = cmp_r[2][7:0];
            TMC_A_CMPC_H: rd_mux = cmp_r[2][15:8];
            TMC_A_CAP_L:  rd_mux = cap_r[7:0];
            TMC_A_CNT_H,
            TMC_A_CAP_H:  rd_mux = hold_r;  // R23
            TMC_A_CTLA:   rd_mux = ctla_r;
            TMC_A_CTLB:   rd_mux = ctlb_r;
            TMC_A_CTLC:   rd_mux = ctlc_r;
            TMC_A_FLAG:   rd_mux = {3'h0, flag_r};
            TMC_A_MASK:   rd_mux = {3'h0, mask_r};
            default:      rd_mux = TMC_BYTE0;
        endcase
    end
    // --------------------------------------------------------------
    // Compare channels
    // --------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gch
            wire [3:0] lo_a = 4'(TMC_A_CMPA_L + 2 * g);
            assign cmp_wr[g] = bus.wr && bus.addr == lo_a && ch_en[g];
            assign match[g]  = ch_en[g] && cnt_r == cmp_r[g];  // R12
            assign fl_set[TMC_FL_CMPA + g] = match[g] && tick;  // R13
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cmp_buf_r[g] <= TMC_FLOOR;
                    cmp_r[g]     <= TMC_FLOOR;
                    oc_r[g]      <= 1'b0;
                end else begin
                    if (cmp_wr[g]) cmp_buf_r[g] <= wide_w;  // R03
                    // Double buffer moves at ceiling, or at once when waveform mode is 0
                    if ((at_top && tick) || wgm == TMC_FLOOR[3:0])
                        cmp_r[g] <= cmp_buf_r[g];  // R18
                    if (ctlc_r[7 - g] || (match[g] && tick))
                        oc_r[g] <= (g == 0 && top_oca) ? 1'b0 : ~oc_r[g];  // R18
                end
            end
        end
    endgenerate
    assign fl_set[TMC_FL_OVF] = at_top && tick;
    assign fl_set[TMC_FL_CAP] = cap_evt;
    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_r  <= TMC_BYTE0;
            cnt_r   <= TMC_FLOOR;
            cap_r   <= TMC_FLOOR;
            ctla_r  <= TMC_BYTE0;
            ctlb_r  <= TMC_BYTE0;
            ctlc_r  <= TMC_BYTE0;
            flag_r  <= '0;
            mask_r  <= '0;
            pre_r   <= '0;
            ext_s_r <= 1'b0;
            ext_d_r <= 1'b0;
            cap_s_r <= 1'b0;
            filt_r  <= '0;
            cap_lvl_r <= 1'b0;
            rdata_r <= TMC_BYTE0;
            irq_r   <= 1'b0;
        end else begin
            pre_r   <= pre_r + 10'h001;
            ext_s_r <= external_count_pin;
            ext_d_r <= ext_s_r;
            cap_s_r <= capture_sel_cmp ? comparator_in : capture_input_pin;
            filt_r  <= {filt_r[TMC_FILT_N-2:0], cap_s_r};
            cap_lvl_r <= cap_lvl;
            if (wr_hi) hold_r <= bus.wdata;  // R22
            else if (rd_cnt_l) hold_r <= cnt_r[15:8];  // R04
            else if (rd_cap_l) hold_r <= cap_r[15:8];  // R04
            if (wr_cnt_l) cnt_r <= wide_w;  // R20
            else if (tick) cnt_r <= cnt_nxt;
            if (cap_evt && !top_cap) cap_r <= cnt_r;  // R14
            else if (wr_cap_l && top_cap) cap_r <= wide_w;  // R03
            if (bus.wr && bus.addr == TMC_A_CTLA) ctla_r <= bus.wdata;  // R09
            if (bus.wr && bus.addr == TMC_A_CTLB) ctlb_r <= bus.wdata;  // R09
            ctlc_r <= (bus.wr && bus.addr == TMC_A_CTLC) ? bus.wdata : TMC_BYTE0;
            if (bus.wr && bus.addr == TMC_A_MASK) mask_r <= bus.wdata[TMC_FL_W-1:0];
            // Set beats a same-cycle write-one clear
            flag_r <= fl_set | (flag_r & ~((bus.wr && bus.addr == TMC_A_FLAG)
                      ? bus.wdata[TMC_FL_W-1:0] : '0));  // R21
            irq_r   <= |(flag_r & mask_r);  // R10
            if (bus.rd) rdata_r <= rd_mux;
        end
    end
    assign bus.rdata          = rdata_r;
    assign bus.irq            = irq_r;
    assign compare_output_pins = oc_r;
    assign counter_value      = cnt_r;
endmodule
`default_nettype wire

// ---- hw/tmc_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module tmc_host (
    input  wire logic        pclk,
    input  wire logic        presetn,
    tmc_if.host              bus,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq_out
);
    import tmc_pkg::*;
    // --------------------------------------------------------------
    // Command register: go, write, wide, address, data
    // --------------------------------------------------------------
    tmc_hstate_t st_r;
    logic [31:0] cmd_r;
    logic [15:0] rd_r;
    logic [3:0]  addr_r;
    logic [7:0]  wdata_r;
    logic        wr_r, rd_r_en, irq_r;
    logic        second_r;
    logic [31:0] prdata_r;
    wire apb_acc  = psel && penable;
    wire go       = apb_acc && pwrite && paddr == TMC_APB_CMD && pwdata[TMC_CMD_GO]
                    && st_r == TMC_H_IDLE;
    wire wide     = cmd_r[TMC_CMD_WIDE];
    wire is_wr    = cmd_r[TMC_CMD_WR];
    wire [3:0] a  = cmd_r[19:16];
    wire busy     = st_r != TMC_H_IDLE;
    logic [31:0] rmux;
    always_comb begin
        unique case (paddr)
            TMC_APB_CMD:  rmux = cmd_r;
            TMC_APB_STAT: rmux = {30'h0, irq_r, busy};
            TMC_APB_RDAT: rmux = {16'h0, rd_r};
            default:      rmux = 32'h0;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= TMC_H_IDLE;
            cmd_r <= 32'h0;
            rd_r <= 16'h0;
            addr_r <= 4'h0;
            wdata_r <= 8'h0;
            wr_r <= 1'b0;
            rd_r_en <= 1'b0;
            irq_r <= 1'b0;
            second_r <= 1'b0;
            prdata_r <= 32'h0;
        end else begin
            irq_r <= bus.irq;
            wr_r <= 1'b0;
            rd_r_en <= 1'b0;
            // Loaded in setup so read data stands through the access phase
            if (psel && !penable && !pwrite) prdata_r <= rmux;
            unique case (st_r)
                TMC_H_IDLE: if (go) begin
                    cmd_r <= pwdata;
                    st_r <= TMC_H_FIRST;
                end
                TMC_H_FIRST: begin
                    // Narrow as given; wide write high first, wide read low first
                    addr_r <= !wide ? a : is_wr ? a | 4'h1 : a & 4'he;  // R06 R07
                    wdata_r <= (wide && is_wr) ? cmd_r[15:8] : cmd_r[7:0];
                    wr_r <= is_wr;
                    rd_r_en <= ~is_wr;
                    second_r <= 1'b0;
                    st_r <= TMC_H_GAP;
                end
                // Byte access on the bus; its read data stands one cycle later
                TMC_H_GAP: st_r <= (wide && !second_r) ? TMC_H_SECOND : TMC_H_DONE;  // R02
                TMC_H_SECOND: begin
                    if (!is_wr) rd_r[7:0] <= bus.rdata;
                    addr_r <= is_wr ? a & 4'he : a | 4'h1;
                    wdata_r <= cmd_r[7:0];
                    wr_r <= is_wr;
                    rd_r_en <= ~is_wr;
                    second_r <= 1'b1;
                    st_r <= TMC_H_GAP;
                end
                TMC_H_DONE: begin
                    if (!is_wr) begin
                        if (wide) rd_r[15:8] <= bus.rdata;
                        else rd_r <= {8'h00, bus.rdata};
                    end
                    cmd_r[TMC_CMD_GO] <= 1'b0;
                    st_r <= TMC_H_IDLE;
                end
                default: st_r <= TMC_H_IDLE;
            endcase
        end
    end
    // Pair is issued by the state machine with one idle cycle between, so no interrupt handler can split it
    assign bus.addr  = addr_r;  // R08
    assign bus.wdata = wdata_r;
    assign bus.wr    = wr_r;
    assign bus.rd    = rd_r_en;
    assign prdata    = prdata_r;
    assign pready    = 1'b1;
    assign pslverr   = 1'b0;
    assign irq_out   = irq_r;
endmodule
`default_nettype wire

// ---- test/tmc_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module tmc_chk
    import tmc_pkg::*;
(
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic       irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Shadow of the mask bits, kept from bus writes only
    logic [4:0] mask_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= 5'h00;
        end else if (wr && addr == TMC_A_MASK) begin
            mask_r <= wdata[4:0];
        end
    end

    // --------
    // Byte bus
    // --------
    property p_wr_gap; wr |=> !(wr || rd); endproperty
    a_wr_gap: assert property (p_wr_gap) else $error("write not followed by idle");
    property p_rd_gap; rd |=> !(wr || rd); endproperty
    a_rd_gap: assert property (p_rd_gap) else $error("read not followed by idle");
    property p_wr_order;
        wr && addr[0] && addr <= TMC_A_CAP_H |-> ##2 (wr && addr == $past(addr, 2) - 4'h1);
    endproperty
    a_wr_order: assert property (p_wr_order) else $error("high write without low");
    property p_rd_order;
        rd && addr[0] && addr <= TMC_A_CAP_H |-> $past(rd, 2) && $past(addr, 2) == addr - 4'h1;
    endproperty
    a_rd_order: assert property (p_rd_order) else $error("high read before low");
    property p_rdata_hold; !rd |=> $stable(rdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_unmapped; rd && addr == 4'hf |=> rdata == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_mask_rb; rd && addr == TMC_A_MASK |=> rdata[4:0] == mask_r; endproperty
    a_mask_rb: assert property (p_mask_rb) else $error("mask readback wrong");
    property p_irq_masked; mask_r == 5'h00 |=> !irq; endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("irq with all masked");
endmodule
`default_nettype wire

// ---- test/tmc_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tmc_tb_top;
    import tmc_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq_out;
    logic        legacy = 1'b0;
    logic        ext_pin = 1'b0;
    logic        cap_pin = 1'b0;
    logic        cmp_in = 1'b0;
    logic        cap_sel = 1'b0;
    logic [15:0] cnt;
    logic [2:0]  ocp;
    logic [15:0] rdv;
    int          err_total = 0;
    int          comparisons = 0;
    int          cycles = 0;

    tmc_if tmc_if_i (.pclk(pclk), .presetn(presetn));
    tmc_host tmc_host_i (.pclk(pclk), .presetn(presetn), .bus(tmc_if_i.host), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq_out(irq_out));
    tmc_dev tmc_dev_i (.pclk(pclk), .presetn(presetn), .bus(tmc_if_i.dev),
        .legacy_mode(legacy), .external_count_pin(ext_pin), .capture_input_pin(cap_pin),
        .comparator_in(cmp_in), .capture_sel_cmp(cap_sel), .compare_output_pins(ocp),
        .counter_value(cnt));
    tmc_chk tmc_chk_i (.pclk(pclk), .presetn(presetn), .addr(tmc_if_i.addr),
        .wdata(tmc_if_i.wdata), .rdata(tmc_if_i.rdata), .wr(tmc_if_i.wr), .rd(tmc_if_i.rd),
        .irq(tmc_if_i.irq));

    initial begin
        forever #2 pclk = ~pclk;
    end

    // --------
    // Shared tasks
    // --------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [31:0] a, d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Busy poll has no local limit; the cycle ceiling cuts a hang
    task automatic cmd(input logic w, wide, input logic [3:0] ba, input logic [15:0] d);
        logic [31:0] r;
        apb(1'b1, TMC_APB_CMD, {1'b1, w, wide, 9'h000, ba, d}, r);
        r = 32'h1;
        while (r[0] !== 1'b0) apb(1'b0, TMC_APB_STAT, 32'h0, r);
        apb(1'b0, TMC_APB_RDAT, 32'h0, r);
        rdv = r[15:0];
    endtask

    // --------
    // Scenarios
    // --------
    task automatic t_bytes();
        logic [31:0] r;
        cmd(1'b1, 1'b1, TMC_A_CNT_L, 16'h1234);
        check(cnt, 16'h1234);
        cmd(1'b0, 1'b1, TMC_A_CNT_L, 16'h0000);
        check(rdv, 16'h1234);
        cmd(1'b1, 1'b1, TMC_A_CMPA_L, 16'h5678);
        cmd(1'b0, 1'b1, TMC_A_CMPA_L, 16'h0000);
        check(rdv, 16'h5678);
        cmd(1'b1, 1'b0, TMC_A_CTLA, 16'h0040);
        cmd(1'b0, 1'b0, TMC_A_CTLA, 16'h0000);
        check(rdv[7:0], 8'h40);
        cmd(1'b1, 1'b0, TMC_A_CTLC, 16'h0020);
        check(ocp, 3'b100);
        cmd(1'b0, 1'b0, 4'hf, 16'h0000);
        check(rdv[7:0], 8'h00);
        apb(1'b0, 32'h0000_0010, 32'h0, r);
        check(pslverr, 1'b0);
        $display("t_bytes done");
    endtask

    task automatic t_legacy();
        legacy <= 1'b1;
        cmd(1'b1, 1'b1, TMC_A_CMPC_L, 16'h3333);
        cmd(1'b0, 1'b1, TMC_A_CMPC_L, 16'h0000);
        check(rdv, 16'h0000);
        legacy <= 1'b0;
        cmd(1'b1, 1'b1, TMC_A_CMPC_L, 16'h3333);
        cmd(1'b0, 1'b1, TMC_A_CMPC_L, 16'h0000);
        check(rdv, 16'h3333);
        $display("t_legacy done");
    endtask

    task automatic t_count();
        logic [15:0] held;
        cmd(1'b1, 1'b1, TMC_A_CMPB_L, 16'h0020);
        cmd(1'b1, 1'b1, TMC_A_CNT_L, 16'h0000);
        cmd(1'b1, 1'b0, TMC_A_FLAG, 16'h001f);
        cmd(1'b1, 1'b0, TMC_A_MASK, 16'h0004);
        cmd(1'b0, 1'b0, TMC_A_MASK, 16'h0000);
        check(rdv[4:0], 5'h04);
        cmd(1'b1, 1'b0, TMC_A_CTLB, {13'h0000, TMC_CS_SYS});
        while (cnt < 16'h0040) @(posedge pclk);
        cmd(1'b0, 1'b0, TMC_A_FLAG, 16'h0000);
        check(rdv[2:1], 2'b10);
        check(irq_out, 1'b1);
        cmd(1'b1, 1'b0, TMC_A_FLAG, 16'h0004);
        check(irq_out, 1'b0);
        cmd(1'b1, 1'b1, TMC_A_CNT_L, 16'h4000);
        check(cnt - 16'h4000 < 16'h0040, 1'b1);
        cmd(1'b1, 1'b0, TMC_A_CTLB, 16'h0000);
        held = cnt;
        repeat (20) @(posedge pclk);
        check(cnt, held);
        // External edges: enable only while the pin is quiet
        cmd(1'b1, 1'b1, TMC_A_CNT_L, 16'h0000);
        cmd(1'b1, 1'b0, TMC_A_CTLB, 16'h0007);
        repeat (5) begin
            repeat (3) @(posedge pclk);
            ext_pin <= 1'b1;
            repeat (3) @(posedge pclk);
            ext_pin <= 1'b0;
        end
        repeat (6) @(posedge pclk);
        check(cnt, 16'h0005);
        cmd(1'b1, 1'b0, TMC_A_CTLB, 16'h0000);
        cmd(1'b1, 1'b0, TMC_A_MASK, 16'h0000);
        $display("t_count done");
    endtask

    task automatic t_cap();
        cmd(1'b1, 1'b1, TMC_A_CNT_L, 16'h0abc);
        cmd(1'b1, 1'b0, TMC_A_CTLB, 16'h0080);
        cmd(1'b1, 1'b0, TMC_A_FLAG, 16'h001f);
        cap_pin <= 1'b1;
        repeat (8) @(posedge pclk);
        cmd(1'b0, 1'b0, TMC_A_FLAG, 16'h0000);
        check(rdv[4], 1'b1);
        check(irq_out, 1'b0);
        cmd(1'b0, 1'b1, TMC_A_CAP_L, 16'h0000);
        check(rdv, 16'h0abc);
        cap_pin <= 1'b0;
        cmd(1'b1, 1'b0, TMC_A_CTLA, 16'h0080);
        cmd(1'b1, 1'b1, TMC_A_CNT_L, 16'h0bcd);
        cmd(1'b1, 1'b0, TMC_A_FLAG, 16'h001f);
        cap_pin <= 1'b1;
        repeat (2) @(posedge pclk);
        cap_pin <= 1'b0;
        repeat (10) @(posedge pclk);
        cmd(1'b0, 1'b0, TMC_A_FLAG, 16'h0000);
        check(rdv[4], 1'b0);
        cap_sel <= 1'b1;
        cmp_in <= 1'b1;
        repeat (12) @(posedge pclk);
        cmd(1'b0, 1'b1, TMC_A_CAP_L, 16'h0000);
        check(rdv, 16'h0bcd);
        $display("t_cap done");
    endtask

    task automatic t_top();
        logic [3:0]  md [4] = '{4'h0, 4'h1, 4'h2, TMC_WGM_CTC_OCA};
        logic [15:0] tp [4] = '{TMC_MAX, TMC_TOP8, TMC_TOP9, 16'h0100};
        logic [15:0] mx;
        logic        fl;
        for (int i = 0; i < 4; i++) begin
            cmd(1'b1, 1'b0, TMC_A_CTLB, 16'h0000);
            cmd(1'b1, 1'b1, TMC_A_CMPA_L, 16'h0100);
            cmd(1'b1, 1'b1, TMC_A_CNT_L, tp[i] - 16'h0080);
            cmd(1'b1, 1'b0, TMC_A_CTLB, {8'h00, 1'b0, md[i], TMC_CS_SYS});
            mx = 16'h0000;
            fl = 1'b0;
            repeat (300) begin
                @(posedge pclk);
                if (cnt > mx) mx = cnt;
                if (cnt === TMC_FLOOR) fl = 1'b1;
            end
            check(mx, tp[i]);
            if (md[i][1:0] == 2'b00) check(fl, 1'b1);
        end
        cmd(1'b1, 1'b0, TMC_A_CTLB, 16'h0000);
        $display("t_top done");
    endtask

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            stop_test();
        end
    end

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_bytes();
        t_legacy();
        t_count();
        t_cap();
        t_top();
        stop_test();
    end
endmodule
`default_nettype wire
